// ==== rtl/dbcs_map.svh ====
// Purpose: Offsets, field positions, reset values and step figures for the
//          second converter command and system status registers.
// Assumes: Included by the package, the ramp and the register block.
// Notes:   Definitions only.
// How it works
// - Bits 6:4 slew code n; target steps 10 mV per 2^n switching cycles.
// - Bits 2:1: 00 mode pin, 01 forced PWM, 10 auto skip, 11 reserved.
// - Bit 0 clear keeps output two enabled; set disables it.
// - Status bit 2 reads 1 while die is above 125 C.
// - Status bit 1 reads 1 while output two is power good.
// - Status bit 0 reads 1 while output one is power good.
// - Seven-bit code maps to 0.68 V plus 10 mV per count, up to 1.95 V.
// - In current-sharing mode the second converter command is unused.
// - Writes ignored while both hardware enables are low.
`ifndef DBCS_MAP_SVH
`define DBCS_MAP_SVH
// ============================================================
// Register map
`define DBCS_CMD2_ADDR 8'h03
`define DBCS_STAT_ADDR 8'h04
`define DBCS_CMD2_RST 8'h00
`define DBCS_STAT_RST 8'h00
`define DBCS_CMD2_WMASK 8'h77
// ============================================================
// Field positions
`define DBCS_SLEW_MSB 6
`define DBCS_SLEW_LSB 4
`define DBCS_LLM_MSB 2
`define DBCS_LLM_LSB 1
`define DBCS_OFF_BIT 0
`define DBCS_HOT_BIT 2
`define DBCS_PG2_BIT 1
`define DBCS_PG1_BIT 0
// ============================================================
// Light-load codes and voltage steps
`define DBCS_LLM_PIN 2'h0
`define DBCS_LLM_PWM 2'h1
`define DBCS_LLM_AUTO 2'h2
`define DBCS_VBASE_MV 11'h2a8
`define DBCS_VSTEP_MV 11'h00a
`endif

// ==== rtl/dbcs_pkg.sv ====
// Purpose: Shared types and the code-to-voltage function.
// Assumes: dbcs_map.svh holds the numbers.
// Notes:   Nothing here holds state.
`include "dbcs_map.svh"
package dbcs_pkg;
    typedef logic [6:0] dbcs_vid_t;
    typedef logic [2:0] dbcs_slew_t;
    typedef logic [10:0] dbcs_mv_t;

    // Linear map of a voltage code to millivolts.
    function automatic dbcs_mv_t dbcs_vid_to_mv(input dbcs_vid_t code);
        dbcs_mv_t scaled;
        scaled = 11'(`DBCS_VSTEP_MV * {4'h0, code});
        return 11'(`DBCS_VBASE_MV + scaled);
    endfunction
endpackage

// ==== rtl/dbcs_ramp.sv ====
// Purpose: Steps the output-two code toward its target at the slew pace.
// Assumes: tick is a one-cycle pulse per switching cycle.
// Notes:   The code holds while go is low.
`timescale 1ns/100ps
`include "dbcs_map.svh"
module dbcs_ramp #(
    parameter int CNT_W = 7
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Ramp link
    dbcs_ramp_if.ramp rif
);
    typedef enum logic {DBCS_IDLE, DBCS_MOVE} dbcs_ramp_e;

    // ============================================================
    // Parameter check
    if (CNT_W < 7) begin : g_bad_cnt
        $error("CNT_W must cover 128 switching cycles");
    end

    dbcs_ramp_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    dbcs_pkg::dbcs_vid_t cur_q, cur_d;
    logic [CNT_W-1:0] limit;

    // ============================================================
    // Stepping
    always_comb begin
        limit = CNT_W'((8'h01 << rif.slew) - 8'h01);
        state_d = state_q;
        cnt_d = cnt_q;
        cur_d = cur_q;
        unique case (state_q)
            DBCS_IDLE: begin
                cnt_d = '0;
                if (rif.go && rif.target != cur_q) begin
                    state_d = DBCS_MOVE;
                end
            end
            DBCS_MOVE: begin
                if (!rif.go || rif.target == cur_q) begin
                    state_d = DBCS_IDLE;
                end else if (rif.tick) begin
                    if (cnt_q == limit) begin
                        cnt_d = '0;
                        cur_d = (rif.target > cur_q) ? 7'(cur_q + 7'h01)
                                                     : 7'(cur_q - 7'h01);
                    end else begin
                        cnt_d = CNT_W'(cnt_q + 1'b1);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DBCS_IDLE;
            cnt_q <= '0;
            cur_q <= 7'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cur_q <= cur_d;
        end
    end

    assign rif.cur = cur_q;
    assign rif.moving = (state_q == DBCS_MOVE);

    // ============================================================
    // Checks
    a_step_on_tick: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(cur_q) |-> $past(rif.tick) && $past(cnt_q) == $past(limit))
        else $error("code moved without a paced tick");
    a_go_gates_code: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !rif.go |=> $stable(cur_q))
        else $error("code moved while go was low");
    a_unit_step: assert property (@(posedge mclk) disable iff (!rst_n)
        $changed(cur_q) |-> (cur_q == 7'($past(cur_q) + 7'h01)) ||
                            (cur_q == 7'($past(cur_q) - 7'h01)))
        else $error("code moved by more than one step");
endmodule // dbcs_ramp

// ==== rtl/dbcs_ramp_if.sv ====
// Purpose: Carries target, pace and progress between register logic and ramp.
// Assumes: One clock domain.
// Notes:   ctrl is the register side, ramp the stepping engine.
`timescale 1ns/100ps
interface dbcs_ramp_if;
    dbcs_pkg::dbcs_vid_t target;
    dbcs_pkg::dbcs_slew_t slew;
    logic go;
    logic tick;
    dbcs_pkg::dbcs_vid_t cur;
    logic moving;
    modport ctrl (output target, slew, go, tick, input cur, moving);
    modport ramp (input target, slew, go, tick, output cur, moving);
endinterface

// ==== rtl/dbcs_regs.sv ====
// Purpose: Second converter command register, system status register and
//          output-two code ramp for a dual buck regulator.
// Assumes: The serial engine presents one decoded write per update on mclk.
// Notes:   Analog status and pins pass a two-flop synchroniser first.
`timescale 1ns/100ps
`include "dbcs_map.svh"
module dbcs_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port from the serial engine
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata_q,
    // Pins and analog flags
    input wire logic hw_enable_one,
    input wire logic hw_enable_two,
    input wire logic light_load_pin,
    input wire logic share_mode_pin,
    input wire logic die_hot,
    input wire logic out1_regulation_ok,
    input wire logic out2_regulation_ok,
    input wire logic sw_clk,
    // Voltage select for converter two
    input wire dbcs_pkg::dbcs_vid_t converter2_voltage_select,
    input wire logic converter2_go,
    // Converter two controls
    output logic out2_off_q,
    output logic out2_auto_skip_q,
    output dbcs_pkg::dbcs_vid_t vout2_code_q,
    output dbcs_pkg::dbcs_mv_t vout2_mv_q,
    output logic vout2_ramping_q
);
    localparam int NPIN = 8;

    // ============================================================
    // Pin synchroniser
    logic [NPIN-1:0] pins, sync1_q, sync2_q, sync1_d, sync2_d;
    logic swclk_prev_q, swclk_prev_d;
    logic hw_off, share, psm_pin, hot, pg1, pg2, sw_s;

    // Every pin and analog flag crosses into mclk here. Two stages keep a
    // metastable sample away from the decode and the status register.
    assign pins = {sw_clk, out2_regulation_ok, out1_regulation_ok, die_hot,
                   share_mode_pin, light_load_pin, hw_enable_two,
                   hw_enable_one};
    assign hw_off = !sync2_q[0] && !sync2_q[1];
    assign psm_pin = sync2_q[2];
    assign share = sync2_q[3];
    assign hot = sync2_q[4];
    assign pg1 = sync2_q[5];
    assign pg2 = sync2_q[6];
    assign sw_s = sync2_q[7];

    // The previous sample resets low, the idle level of the switching
    // clock, so no false tick follows reset.
    always_comb begin
        sync1_d = pins;
        sync2_d = sync1_q;
        swclk_prev_d = sw_s;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            swclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            swclk_prev_q <= swclk_prev_d;
        end
    end

    // ============================================================
    // Registers
    logic [7:0] cmd_q, cmd_d, stat_q, stat_d, rdata_d;
    logic off_d, skip_d, cmd_wr;
    logic [1:0] llm;

    dbcs_ramp_if rif ();

    always_comb begin
        // A write needs a hardware enable; software disable keeps access.
        cmd_wr = reg_wr && reg_addr == `DBCS_CMD2_ADDR && !hw_off;
        cmd_d = cmd_q;
        if (cmd_wr) begin
            cmd_d = reg_wdata & `DBCS_CMD2_WMASK;
        end
        // Status is rebuilt every cycle from the pins, so nothing sticks.
        stat_d = `DBCS_STAT_RST;
        stat_d[`DBCS_HOT_BIT] = hot;
        stat_d[`DBCS_PG2_BIT] = pg2;
        stat_d[`DBCS_PG1_BIT] = pg1;
        // Read data is registered: it shows a register one cycle after the
        // address settles, which the serial engine has bit times to spare.
        unique case (reg_addr)
            `DBCS_CMD2_ADDR: rdata_d = cmd_q;
            `DBCS_STAT_ADDR: rdata_d = stat_q;
            default: rdata_d = 8'h00;
        endcase
        // Sharing makes converter two a slave; its command falls back.
        llm = share ? `DBCS_LLM_PIN
                    : cmd_q[`DBCS_LLM_MSB:`DBCS_LLM_LSB];
        off_d = share ? 1'b0 : cmd_q[`DBCS_OFF_BIT];
        unique case (llm)
            `DBCS_LLM_PIN: skip_d = psm_pin;
            `DBCS_LLM_PWM: skip_d = 1'b0;
            `DBCS_LLM_AUTO: skip_d = 1'b1;
            default: skip_d = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= `DBCS_CMD2_RST;
            stat_q <= `DBCS_STAT_RST;
            reg_rdata_q <= 8'h00;
            out2_off_q <= 1'b0;
            out2_auto_skip_q <= 1'b0;
            vout2_code_q <= 7'h00;
            vout2_mv_q <= `DBCS_VBASE_MV;
            vout2_ramping_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            stat_q <= stat_d;
            reg_rdata_q <= rdata_d;
            out2_off_q <= off_d;
            out2_auto_skip_q <= skip_d;
            vout2_code_q <= rif.cur;
            vout2_mv_q <= dbcs_pkg::dbcs_vid_to_mv(rif.cur);
            vout2_ramping_q <= rif.moving;
        end
    end

    // ============================================================
    // Ramp engine
    // Writes in sharing mode still land in the command register; only their
    // effect is masked, so the stored setting returns when sharing ends.
    assign rif.target = converter2_voltage_select;
    assign rif.go = converter2_go && !share;
    assign rif.slew = share ? 3'h0
                            : cmd_q[`DBCS_SLEW_MSB:`DBCS_SLEW_LSB];
    assign rif.tick = sw_s && !swclk_prev_q;

    dbcs_ramp #(.CNT_W(7)) u_ramp (
        .mclk(mclk),
        .rst_n(rst_n),
        .rif(rif)
    );

    // ============================================================
    // Checks
    a_slew_stored: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr |=> cmd_q[6:4] == $past(reg_wdata[6:4]))
        else $error("slew field not stored");
    a_pwm_forced: assert property (@(posedge mclk) disable iff (!rst_n)
        !share && cmd_q[2:1] == 2'h1 |=> !out2_auto_skip_q)
        else $error("forced PWM not applied");
    a_off_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        !share ##1 !$past(share) |-> out2_off_q == $past(cmd_q[0]))
        else $error("output disable does not follow bit 0");
    a_hot_status: assert property (@(posedge mclk) disable iff (!rst_n)
        ##4 stat_q[2] == $past(die_hot, 3))
        else $error("temperature warning wrong");
    a_pg2_status: assert property (@(posedge mclk) disable iff (!rst_n)
        ##4 stat_q[1] == $past(out2_regulation_ok, 3))
        else $error("output two power good wrong");
    a_pg1_status: assert property (@(posedge mclk) disable iff (!rst_n)
        ##4 stat_q[0] == $past(out1_regulation_ok, 3))
        else $error("output one power good wrong");
    a_mv_matches: assert property (@(posedge mclk) disable iff (!rst_n)
        vout2_mv_q == 11'(11'h2a8 + 11'(11'h00a * {4'h0, vout2_code_q})))
        else $error("millivolt output disagrees with code");
    a_reserved_zero: assert property (@(posedge mclk)
        disable iff (!rst_n)
        reg_addr == 8'h04 |=> reg_rdata_q[7:3] == 5'h00)
        else $error("reserved status bits not zero");
    a_hw_off_block: assert property (@(posedge mclk)
        disable iff (!rst_n)
        hw_off && reg_wr |=> $stable(cmd_q))
        else $error("write taken during hardware shutdown");
    a_share_unused: assert property (@(posedge mclk)
        disable iff (!rst_n)
        share |=> !out2_off_q)
        else $error("converter two command acted in sharing mode");

    // ============================================================
    // Decode and bus checks
    a_auto_skip: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !share && cmd_q[2:1] == 2'h2 |=> out2_auto_skip_q)
        else $error("auto pulse-skip not applied");
    a_skip_reserved: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !share && cmd_q[2:1] == 2'h3 |=> !out2_auto_skip_q)
        else $error("reserved light-load code not held at PWM");
    a_pin_mode: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !share && cmd_q[2:1] == 2'h0 |=> out2_auto_skip_q == $past(psm_pin))
        else $error("light-load mode does not follow the pin");
    a_share_pin_mode: assert property (@(posedge mclk)
        disable iff (!rst_n)
        share |=> out2_auto_skip_q == $past(psm_pin))
        else $error("sharing mode does not follow the pin");
    a_cmd_readback: assert property (@(posedge mclk)
        disable iff (!rst_n)
        reg_addr == `DBCS_CMD2_ADDR |=> reg_rdata_q == $past(cmd_q))
        else $error("command read data wrong");
    a_status_readback: assert property (@(posedge mclk)
        disable iff (!rst_n)
        reg_addr == `DBCS_STAT_ADDR |=> reg_rdata_q == $past(stat_q))
        else $error("status read data wrong");
    a_unmapped_zero: assert property (@(posedge mclk)
        disable iff (!rst_n)
        reg_addr != `DBCS_CMD2_ADDR && reg_addr != `DBCS_STAT_ADDR
            |=> reg_rdata_q == 8'h00)
        else $error("unmapped address read not zero");
    a_write_taken: assert property (@(posedge mclk)
        disable iff (!rst_n)
        cmd_wr |=> cmd_q == ($past(reg_wdata) & `DBCS_CMD2_WMASK))
        else $error("enabled write not stored");
    a_no_stray_write: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !(reg_wr && reg_addr == `DBCS_CMD2_ADDR) |=> $stable(cmd_q))
        else $error("command changed without a write to it");
    a_reserved_cmd: assert property (@(posedge mclk)
        disable iff (!rst_n)
        reg_addr == `DBCS_CMD2_ADDR |=> !reg_rdata_q[7] && !reg_rdata_q[3])
        else $error("reserved command bits not zero");
    // The code holds two edges on: one for the engine, one for the output.
    a_share_frozen: assert property (@(posedge mclk)
        disable iff (!rst_n)
        share |-> ##2 $stable(vout2_code_q))
        else $error("code moved in sharing mode");
    a_go_freezes_code: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !converter2_go |-> ##2 $stable(vout2_code_q))
        else $error("code moved while go was low");
    a_tick_single: assert property (@(posedge mclk)
        disable iff (!rst_n)
        rif.tick |=> !rif.tick)
        else $error("switching tick longer than one cycle");
endmodule // dbcs_regs

// ==== sim/dbcs_host_model.sv ====
// Purpose: Serial engine stand-in issuing decoded register updates.
// Assumes: Inputs change at the falling edge of mclk.
// Notes:   Write data shows the inverse of the last byte between updates.
`timescale 1ns/100ps
module dbcs_host_model (
    // Register port
    input wire logic mclk,
    input wire logic [7:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr
);
    // ============================================================
    // Transfers
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    // A stale byte must never look like a valid one to the device.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        d = reg_rdata_q;
    endtask
endmodule // dbcs_host_model

// ==== sim/dbcs_regs_bench.sv ====
// Purpose: Self-checking bench for the converter two command and status.
// Assumes: Pins need three edges to reach the registers.
// Notes:   Ramp pace is judged to within one switching cycle.
`timescale 1ns/100ps
module dbcs_regs_bench;
    logic mclk, rst_n, wr, en1, en2, llp, shp, hot, ok1, ok2, sw, go;
    logic off, skip, ramping;
    logic [7:0] addr, wdata, rdata, rd_v, d, cmd;
    logic [6:0] tgt, code, c0;
    logic [10:0] mv;
    logic [7:0] cmd_model[$];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int rises;
    int exp_r;

    dbcs_host_model i_host (.mclk(mclk), .reg_rdata_q(rdata),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr));
    dbcs_regs i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rdata_q(rdata),
        .hw_enable_one(en1), .hw_enable_two(en2), .light_load_pin(llp),
        .share_mode_pin(shp), .die_hot(hot), .out1_regulation_ok(ok1),
        .out2_regulation_ok(ok2), .sw_clk(sw),
        .converter2_voltage_select(tgt), .converter2_go(go),
        .out2_off_q(off), .out2_auto_skip_q(skip), .vout2_code_q(code),
        .vout2_mv_q(mv), .vout2_ramping_q(ramping));

    // ============================================================
    // Checking
    task automatic miss(input logic [10:0] g, input logic [10:0] e);
        n_fail++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) miss({3'h0, g}, {3'h0, e});
    endtask
    task automatic chk_flag(input logic g, input logic e);
        total_checks++;
        if (g !== e) miss({10'h0, g}, {10'h0, e});
    endtask
    task automatic chk_mv(input logic [10:0] g, input logic [10:0] e);
        total_checks++;
        if (g !== e) miss(g, e);
    endtask
    function automatic logic exp_skip(input logic [7:0] c, input logic p);
        return (c[2:1] == 2'h2) || (c[2:1] == 2'h0 && p);
    endfunction
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Steps the switching clock until the code lands, counting edges.
    task automatic ramp(input int n);
        c0 = code;
        rises = 0;
        exp_r = (int'(tgt) - int'(c0)) << n;
        repeat (2) @(negedge mclk);
        chk_flag(ramping, 1'b1);
        while (code !== tgt && rises < 300) begin
            sw = 1'b1;
            repeat (4) @(negedge mclk);
            sw = 1'b0;
            repeat (4) @(negedge mclk);
            rises++;
        end
        chk_flag(1'(rises >= exp_r - 1 && rises <= exp_r + 1), 1'b1);
        chk_mv(mv, 11'(680 + 10 * int'(tgt)));
        chk_reg({1'b0, code}, {1'b0, tgt});
        chk_flag(ramping, 1'b0);
    endtask

    // ============================================================
    // Clock, timeout and sequence
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        {rst_n, en1, en2, llp, shp, hot, ok1, ok2, sw, go} = 10'h000;
        tgt = 7'h00;
        void'($urandom(32'ha5ae205b));
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        chk_mv(mv, 11'h2a8);
        for (int a = 3; a < 6; a++) begin
            i_host.rd(8'(a), rd_v);
            chk_reg(rd_v, 8'h00);
        end
        i_host.wr(8'h03, 8'h01);
        repeat (4) @(negedge mclk);
        chk_flag(off, 1'b0);
        en2 = 1'b1;
        repeat (5) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[2:1] = 2'(i);
            llp = 1'($urandom);
            cmd = d & 8'h77;
            cmd_model.push_back(cmd);
            i_host.wr(8'h03, d);
            repeat (4) @(negedge mclk);
            i_host.rd(8'h03, rd_v);
            chk_reg(rd_v, cmd_model.pop_front());
            chk_flag(off, cmd[0]);
            chk_flag(skip, exp_skip(cmd, llp));
        end
        for (int i = 0; i < 4; i++) begin
            {hot, ok1, ok2} = 3'($urandom);
            i_host.wr(8'h04, 8'($urandom));
            i_host.wr(8'h06, 8'($urandom));
            repeat (5) @(negedge mclk);
            i_host.rd(8'h04, rd_v);
            chk_reg(rd_v, {5'h00, hot, ok2, ok1});
        end
        i_host.rd(8'h03, rd_v);
        chk_reg(rd_v, cmd);
        i_host.wr(8'h03, 8'h01);
        shp = 1'b1;
        repeat (5) @(negedge mclk);
        chk_flag(off, 1'b0);
        shp = 1'b0;
        repeat (5) @(negedge mclk);
        chk_flag(off, 1'b1);
        i_host.wr(8'h03, 8'h20);
        tgt = 7'h05;
        go = 1'b1;
        ramp(2);
        i_host.wr(8'h03, 8'h00);
        tgt = 7'h7f;
        ramp(0);
        go = 1'b0;
        tgt = 7'h00;
        repeat (4) begin
            sw = 1'b1;
            repeat (4) @(negedge mclk);
            sw = 1'b0;
            repeat (4) @(negedge mclk);
        end
        chk_reg({1'b0, code}, 8'h7f);
        chk_flag(ramping, 1'b0);
        chk_mv(mv, 11'(680 + 10 * 127));
        tally_and_finish();
    end
endmodule // dbcs_regs_bench
